// *** design/cbt_pkg.sv ***
/*
 * Constants and types for the CAN bit timing block.
 * Assumes an 8-bit register port and a single oscillator-derived clock.
 */
package cbt_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam int         ADDR_W       = 4;
    localparam int         DATA_W       = 8;
    localparam logic [3:0] OFS_PRESCALE = 4'h0;   // Prescaler and jump width
    localparam logic [3:0] OFS_SEGMENT  = 4'h1;   // Segments and sample mode
    localparam logic [3:0] OFS_PHASE2   = 4'h2;   // Explicit phase two length
    localparam logic [3:0] OFS_STATUS   = 4'h3;   // Read-only state
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_SEGMENT  = 8'h00;
    localparam logic [7:0] RST_PHASE2   = 8'h00;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int PS_BRP_LSB    = 0;   // 6 bits, rate_prescaler minus one
    localparam int PS_SJW_LSB    = 6;   // 2 bits, jump_width_limit minus one
    localparam int SG_PROP_LSB   = 0;   // 3 bits, length minus one
    localparam int SG_PH1_LSB    = 3;   // 3 bits, length minus one
    localparam int SG_TRIPLE_BIT = 6;   // Three-sample majority mode
    localparam int SG_PH2SEL_BIT = 7;   // Phase two from OFS_PHASE2
    localparam int P2_LEN_LSB    = 0;   // 3 bits, length minus one

    // ****************************************************
    // Timing in time_quantum units
    // ****************************************************
    localparam logic [3:0] SYNC_TQ    = 4'h1;
    localparam logic [3:0] IPT_TQ     = 4'h2;   // processing_time
    localparam logic [3:0] PH2_MIN_TQ = 4'h2;

    typedef enum logic [1:0] {
        SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2
    } cbt_seg_e;

endpackage

// *** design/cbt_bit_timing.sv ***
/*
 * Bit timing logic: time_quantum prescaler, segment sequencer, sampling,
 * hard and resynchronization, transmit bit pacing.
 * Assumes can_rx comes straight from the transceiver pin, and that
 * tx_bit, tx_active and bus_idle come from frame logic on ref_clk.
 */
// Strobed register access and the register offsets are this design's own decisions.
//
// Functional notes
// - Bit is sync, propagation, phase one, two.
// - Sync segment lasts exactly one quantum.
// - Propagation segment programmable one to eight.
// - Phase one 1..8, phase two 2..8.
// - Resync lengthens phase one or shortens two.
// - Single mode samples once at phase one end.
// - Triple mode: majority of three, half-quantum spaced.
// - Processing time is two quanta from sample.
// - Phase two never below processing time.
// - Jump width one to four quanta.
// - Stuffing gives an edge every six bits.
// - Same timing serves receive and transmit.
// - Bit rate from prescaler and segment lengths.
// - Quantum is twice oscillator times prescaler.
// - Hard sync on idle falling edge restarts bit.
// - Falling edges only, one sync per bit (here resync only; repeated hard syncs on idle are not limited).
`timescale 1ns/10ps
module cbt_bit_timing (
    input  wire logic              ref_clk,       // Oscillator clock
    input  wire logic              rst,           // Synchronous reset
    input  wire logic [3:0]        addr,          // Register address
    input  wire logic [7:0]        wr_data,       // Register write data
    input  wire logic              wr_stb,        // Write strobe
    input  wire logic              rd_stb,        // Read strobe
    output logic      [7:0]        rd_data,       // Read data, next cycle
    input  wire logic              can_rx,        // Bus level from pin
    input  wire logic              tx_bit,        // Next bit to send
    input  wire logic              tx_active,     // Node is transmitting
    input  wire logic              bus_idle,      // Frame logic sees idle bus
    output logic                   can_tx,        // Bus level to pin
    output logic                   tx_bit_req,    // Pulse: bit started
    output logic                   sample_strobe, // Pulse: sample point
    output logic                   rx_bit,        // Sampled bus value
    output logic                   rx_bit_valid   // Pulse: bit resolved
);

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0]           reg_pre;
    logic [7:0]           reg_seg;
    logic [7:0]           reg_ph2;
    logic                 rx_m;
    logic                 rx_s;
    logic                 rx_d;
    logic [6:0]           clk_cnt;
    logic [1:0]           hist;
    cbt_pkg::cbt_seg_e    seg;
    logic [3:0]           seg_left;
    logic [4:0]           tq_in_bit;
    logic [3:0]           ph2_q;
    logic [3:0]           ext;
    logic                 synced;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic cbt_pkg::cbt_seg_e seg_succ(input cbt_pkg::cbt_seg_e s);
        case (s)
            cbt_pkg::SEG_SYNC: seg_succ = cbt_pkg::SEG_PROP;
            cbt_pkg::SEG_PROP: seg_succ = cbt_pkg::SEG_PH1;
            cbt_pkg::SEG_PH1:  seg_succ = cbt_pkg::SEG_PH2;
            default:           seg_succ = cbt_pkg::SEG_SYNC;
        endcase
    endfunction

    // ****************************************************
    // Configuration decode
    // ****************************************************
    // Lengths are stored minus one, so every code is legal
    wire [5:0] rate_prescaler      = reg_pre[cbt_pkg::PS_BRP_LSB +: 6];
    wire [3:0] sjw_len  = {2'h0, reg_pre[cbt_pkg::PS_SJW_LSB +: 2]} + 4'h1;
    wire [3:0] prop_len = {1'b0, reg_seg[cbt_pkg::SG_PROP_LSB +: 3]} + 4'h1;
    wire [3:0] ph1_len  = {1'b0, reg_seg[cbt_pkg::SG_PH1_LSB +: 3]} + 4'h1;
    wire       triple   = reg_seg[cbt_pkg::SG_TRIPLE_BIT];
    wire [3:0] ph2_exp  = {1'b0, reg_ph2[cbt_pkg::P2_LEN_LSB +: 3]} + 4'h1;
    wire [3:0] ph2_base = reg_seg[cbt_pkg::SG_PH2SEL_BIT] ? ph2_exp : ph1_len;
    // A one-quantum phase two would cut into processing time
    wire [3:0] ph2_len  = (ph2_base < cbt_pkg::PH2_MIN_TQ) ?
                          cbt_pkg::PH2_MIN_TQ : ph2_base;

    // ****************************************************
    // Quantum prescaler
    // ****************************************************
    // 2*(brp+1) clocks per quantum, so the half point is a whole clock
    wire [6:0] tq_last   = {rate_prescaler, 1'b1};
    wire [6:0] half_last = {1'b0, rate_prescaler};
    wire       tq_tick   = (clk_cnt == tq_last);
    wire       half_tick = (clk_cnt == half_last);

    // ****************************************************
    // Edge and synchronization decode
    // ****************************************************
    wire       fall      = rx_d & ~rx_s;
    wire       hard_go   = fall & bus_idle;
    // Edge counts only if last sample was recessive, once per bit
    wire       resync_go = fall & ~bus_idle & rx_bit & ~synced;
    wire       e_pos     = (seg == cbt_pkg::SEG_PROP) || (seg == cbt_pkg::SEG_PH1);
    wire       e_neg     = (seg == cbt_pkg::SEG_PH2);
    wire [3:0] pos_adj   = (tq_in_bit > {1'b0, sjw_len}) ? sjw_len : tq_in_bit[3:0];
    wire [3:0] neg_adj   = (seg_left > sjw_len) ? sjw_len : seg_left;
    wire [3:0] neg_left  = seg_left - neg_adj;
    wire [3:0] ph2_floor = (ph2_q < cbt_pkg::IPT_TQ) ? (cbt_pkg::IPT_TQ - ph2_q) : 4'h0;
    wire [3:0] neg_fl    = (neg_left < ph2_floor) ? ph2_floor : neg_left;
    // Negative error within the jump width acts like a hard restart
    wire       restart   = hard_go | (resync_go & e_neg & (neg_fl == 4'h0));
    wire       vote      = maj3(hist[1], hist[0], rx_s);

    // ****************************************************
    // Segment sequencer
    // ****************************************************
    cbt_pkg::cbt_seg_e    next_seg;
    logic [3:0]           next_left;
    logic [3:0]           adj_left;
    logic [4:0]           next_tqb;
    logic [3:0]           next_ph2q;
    logic [3:0]           next_ext;
    logic                 next_synced;
    logic [6:0]           next_cnt;
    logic                 next_start;
    logic                 next_sample;
    logic                 next_valid;

    // Adjustment first, then the quantum tick consumes it
    always_comb begin
        next_seg    = seg;
        adj_left    = seg_left;
        next_left   = seg_left;
        next_tqb    = tq_in_bit;
        next_ph2q   = ph2_q;
        next_ext    = ext;
        next_synced = synced;
        next_cnt    = tq_tick ? 7'h00 : clk_cnt + 7'h01;
        next_start  = 1'b0;
        next_sample = 1'b0;
        next_valid  = 1'b0;
        if (restart) begin
            next_seg    = cbt_pkg::SEG_SYNC;
            next_left   = cbt_pkg::SYNC_TQ;
            next_cnt    = 7'h00;
            next_tqb    = 5'h00;
            next_ext    = 4'h0;
            next_synced = 1'b1;
            next_start  = 1'b1;
        end else begin
            if (resync_go) begin
                next_synced = 1'b1;
                // A transmitter ignores positive phase errors
                if (e_pos && !tx_active) begin
                    next_ext = pos_adj;
                    if (seg == cbt_pkg::SEG_PH1) begin
                        adj_left = seg_left + pos_adj;
                    end
                end else if (e_neg) begin
                    adj_left = neg_fl;
                end
            end
            next_left = adj_left;
            if (tq_tick) begin
                next_tqb  = tq_in_bit + 5'h01;
                next_left = adj_left - 4'h1;
                if (e_neg) begin
                    next_ph2q = ph2_q + 4'h1;
                    next_valid = (ph2_q == cbt_pkg::IPT_TQ - 4'h1);
                end
                if (adj_left == 4'h1) begin
                    next_seg = seg_succ(seg);
                    case (seg)
                        cbt_pkg::SEG_SYNC: begin
                            next_left = prop_len;
                        end
                        cbt_pkg::SEG_PROP: begin
                            next_left = ph1_len + next_ext;
                        end
                        cbt_pkg::SEG_PH1: begin
                            next_left   = ph2_len;
                            next_ph2q   = 4'h0;
                            next_sample = 1'b1;
                        end
                        default: begin
                            next_left   = cbt_pkg::SYNC_TQ;
                            next_tqb    = 5'h00;
                            next_ext    = 4'h0;
                            next_synced = 1'b0;
                            next_start  = 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************************
    // Read decode
    // ****************************************************
    wire [7:0] status  = {3'h0, can_tx, synced, rx_bit, seg};
    wire [7:0] rd_mux  = (addr == cbt_pkg::OFS_PRESCALE) ? reg_pre :
                         (addr == cbt_pkg::OFS_SEGMENT)  ? reg_seg :
                         (addr == cbt_pkg::OFS_PHASE2)   ? reg_ph2 :
                         (addr == cbt_pkg::OFS_STATUS)   ? status  : 8'h00;

    // Register port; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_pre <= cbt_pkg::RST_PRESCALE;
            reg_seg <= cbt_pkg::RST_SEGMENT;
            reg_ph2 <= cbt_pkg::RST_PHASE2;
            rd_data <= 8'h00;
        end else begin
            if (wr_stb && addr == cbt_pkg::OFS_PRESCALE) reg_pre <= wr_data;
            if (wr_stb && addr == cbt_pkg::OFS_SEGMENT)  reg_seg <= wr_data;
            if (wr_stb && addr == cbt_pkg::OFS_PHASE2)   reg_ph2 <= wr_data;
            rd_data <= rd_stb ? rd_mux : 8'h00;
        end
    end

    // Pin synchronizer; rx_d only delays rx_s for edge detection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_m <= 1'b1;
            rx_s <= 1'b1;
            rx_d <= 1'b1;
            hist <= 2'h3;
        end else begin
            rx_m <= can_rx;
            rx_s <= rx_m;
            rx_d <= rx_s;
            if (tq_tick || half_tick) hist <= {hist[0], rx_s};
        end
    end

    // Sequencer state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seg       <= cbt_pkg::SEG_SYNC;
            seg_left  <= cbt_pkg::SYNC_TQ;
            clk_cnt   <= 7'h00;
            tq_in_bit <= 5'h00;
            ph2_q     <= 4'h0;
            ext       <= 4'h0;
            synced    <= 1'b0;
        end else begin
            seg       <= next_seg;
            seg_left  <= next_left;
            clk_cnt   <= next_cnt;
            tq_in_bit <= next_tqb;
            ph2_q     <= next_ph2q;
            ext       <= next_ext;
            synced    <= next_synced;
        end
    end

    // Outputs; transmit shares the recovered bit clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            can_tx        <= 1'b1;
            tx_bit_req    <= 1'b0;
            sample_strobe <= 1'b0;
            rx_bit        <= 1'b1;
            rx_bit_valid  <= 1'b0;
        end else begin
            if (next_start) can_tx <= tx_bit;
            tx_bit_req    <= next_start;
            sample_strobe <= next_sample;
            if (next_sample) rx_bit <= triple ? vote : rx_s;
            rx_bit_valid  <= next_valid;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_ph1_end;
        tq_tick && seg == cbt_pkg::SEG_PH1 && adj_left == 4'h1 && !restart;
    endsequence

    sequence s_ph2_end;
        tq_tick && seg == cbt_pkg::SEG_PH2 && adj_left == 4'h1 && !restart;
    endsequence

    a_sync_one_tq: assert property (
        tq_tick && seg == cbt_pkg::SEG_SYNC && !restart |=> seg == cbt_pkg::SEG_PROP)
        else $error("sync segment longer than one quantum");
    a_seg_order: assert property (
        seg != $past(seg) && seg != cbt_pkg::SEG_SYNC |-> seg == seg_succ($past(seg)))
        else $error("segment order broken");
    a_prop_range: assert property (
        prop_len >= 4'h1 && prop_len <= 4'h8)
        else $error("propagation length out of range");
    a_phase_range: assert property (
        ph1_len >= 4'h1 && ph1_len <= 4'h8 && ph2_len >= 4'h2 && ph2_len <= 4'h8)
        else $error("phase length out of range");
    a_ph1_sample: assert property (
        s_ph1_end |=> sample_strobe && seg == cbt_pkg::SEG_PH2)
        else $error("sample not at end of phase one");
    a_majority_vote: assert property (
        s_ph1_end ##1 triple |-> rx_bit == $past(vote))
        else $error("triple sample vote wrong");
    a_ipt_delay: assert property (
        rx_bit_valid |-> $past(tq_tick) && $past(ph2_q) == 4'h1 && $past(e_neg))
        else $error("bit handed over at wrong time");
    a_ph2_floor: assert property (
        s_ph2_end |-> ph2_q >= cbt_pkg::IPT_TQ - 4'h1)
        else $error("phase two shorter than processing time");
    a_jump_bound: assert property (
        resync_go && e_neg && !restart |-> seg_left - neg_fl <= sjw_len)
        else $error("jump exceeds limit");
    a_fall_only: assert property (
        $rose(synced) |-> $past(fall))
        else $error("sync without falling edge");
    a_hard_restart: assert property (
        hard_go |=> seg == cbt_pkg::SEG_SYNC && clk_cnt == 7'h00 && synced)
        else $error("hard sync did not restart bit");
    a_tq_period: assert property (
        tq_tick |-> clk_cnt == {reg_pre[5:0], 1'b0} + 7'h01)
        else $error("quantum length wrong");

    // Transmit level may only move where a new bit starts
    a_tx_at_start: assert property (
        can_tx != $past(can_tx) |-> tx_bit_req)
        else $error("transmit level changed mid-bit");
    // Lengthening of phase one is never zero and never past the limit
    a_pos_bound: assert property (
        resync_go && e_pos && !tx_active && !restart |=> ext != 4'h0 && ext <= $past(sjw_len))
        else $error("phase one lengthened beyond limit");
    // Hand-over never coincides with the sample it resolves
    a_valid_late: assert property (
        sample_strobe |-> !rx_bit_valid)
        else $error("bit handed over at sample point");

endmodule

// *** bench/cbt_far_node.sv ***
/*
 * Model of a far CAN node: sends one frame on can_rx with its own bit length.
 * Assumes ref_clk from the bench; the line rests recessive (1) outside frames.
 */
`timescale 1ns/10ps
module cbt_far_node (
    input  wire logic        ref_clk,  // Bench clock
    input  wire logic        start,    // Pulse: send frame
    input  wire logic [63:0] frame,    // Bits, first in [0]
    input  wire logic [6:0]  nbits,    // Frame length in bits
    input  wire logic [7:0]  bit_clks, // Own bit length in clocks
    output logic             can_rx,   // Bus level at device pin
    output logic             busy      // Frame in progress
);
    // ********
    // Bit sender
    // ********
    logic [6:0] idx;
    logic [7:0] cnt;
    initial begin
        can_rx = 1'b1;
        busy = 1'b0;
        idx = '0;
        cnt = '0;
    end
    // Own bit length differs from the device, so edges drift as on a real bus
    always @(posedge ref_clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            idx <= '0;
            cnt <= '0;
            can_rx <= frame[0];
        end else if (busy) begin
            if (cnt == bit_clks - 8'h01) begin
                cnt <= '0;
                if (idx == nbits - 7'h01) begin
                    busy <= 1'b0;
                    can_rx <= 1'b1; // Released line goes recessive
                end else begin
                    idx <= idx + 7'h01;
                    can_rx <= frame[idx + 7'h01];
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// *** bench/cbt_bit_timing_bench.sv ***
/*
 * Self-checking bench for the bit timing block: register port, bit pacing,
 * and reception of frames from a drifting far node.
 * Assumes cbt_pkg and the far node model are compiled first.
 */
`timescale 1ns/10ps
module cbt_bit_timing_bench;
    logic        ref_clk, rst, wr_stb, rd_stb, can_rx, tx_bit, tx_active, bus_idle;
    logic [3:0]  addr;
    logic [7:0]  wr_data, rd_data, bit_clks;
    logic        can_tx, tx_bit_req, sample_strobe, rx_bit, rx_bit_valid, start, busy;
    logic [63:0] frame;
    logic [6:0]  nbits;
    logic        rd_pend, hunt, nb;
    int          compares, miscompares, cyc, t_req, t_smp;
    int          q_per[$], q_smp[$], q_val[$];
    logic [7:0]  q_rd[$];
    logic        q_tx[$], q_bit[$];

    cbt_bit_timing DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .can_rx(can_rx),
        .tx_bit(tx_bit), .tx_active(tx_active), .bus_idle(bus_idle), .can_tx(can_tx),
        .tx_bit_req(tx_bit_req), .sample_strobe(sample_strobe), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    cbt_far_node far_node (.ref_clk(ref_clk), .start(start), .frame(frame),
        .nbits(nbits), .bit_clks(bit_clks), .can_rx(can_rx), .busy(busy));

    always #20 ref_clk = ~ref_clk;

    // ********
    // Compare, report and bus tasks
    // ********
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        miscompares++;
        $display("unexpected at %0t: got %h exp %h", $time, g, e);
    endtask
    task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask
    task automatic cmp_time(input int g, input int e);
        compares++;
        if (g != e) bad(g, e);
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        compares++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask
    task automatic tmo();
        bad(32'h0, 32'h1);
        stop_test();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        q_rd.push_back(e);
    endtask
    task automatic idle();
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    endtask
    task automatic wait_req();
        int i;
        for (i = 0; i < 4000 && tx_bit_req !== 1'b1; i++) @(posedge ref_clk);
        if (i == 4000) tmo();
        @(posedge ref_clk);
    endtask
    // Program, read back, then note three bits of expected pacing
    task automatic timing(input logic [7:0] ps, input logic [7:0] sg, input logic [7:0] p2);
        int q, pl, h1, h2, i;
        wr(cbt_pkg::OFS_PRESCALE, ps);
        wr(cbt_pkg::OFS_SEGMENT, sg);
        wr(cbt_pkg::OFS_PHASE2, p2);
        wr(4'hC, 8'hFF);
        rd(cbt_pkg::OFS_PRESCALE, ps);
        rd(cbt_pkg::OFS_SEGMENT, sg);
        rd(cbt_pkg::OFS_PHASE2, p2);
        rd(4'hC, 8'h00);
        idle();
        q = 2 * (int'(ps[5:0]) + 1);
        pl = int'(sg[2:0]) + 1;
        h1 = int'(sg[5:3]) + 1;
        h2 = sg[7] ? int'(p2[2:0]) + 1 : h1;
        if (h2 < 2) h2 = 2;
        wait_req();
        wait_req();
        @(negedge ref_clk);
        for (i = 0; i < 3; i++) begin
            q_per.push_back((1 + pl + h1 + h2) * q);
            q_smp.push_back((1 + pl + h1) * q);
            q_val.push_back(2 * q);
        end
        for (i = 0; i < 9000 && q_per.size() != 0; i++) @(posedge ref_clk);
        if (q_per.size() != 0) tmo();
    endtask
    // One stuffed frame from the far node, hard sync on its first edge
    task automatic send(input logic [7:0] clks, input logic act);
        logic [63:0] f;
        logic        b;
        int          n, run;
        f = '1;
        f[0] = 1'b0;
        run = 1;
        for (n = 1; n < 40; n++) begin
            b = 1'($urandom);
            if (run == 5) b = ~f[n-1]; // Forced edge
            run = (b == f[n-1]) ? run + 1 : 1;
            f[n] = b;
        end
        for (n = 0; n < 40; n++) q_bit.push_back(f[n]);
        hunt = 1'b1;
        frame <= f;
        nbits <= 7'h28;
        bit_clks <= clks;
        tx_active <= act;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (40) @(posedge ref_clk);
        bus_idle <= 1'b0;
        for (n = 0; n < 9000 && q_bit.size() != 0; n++) @(posedge ref_clk);
        if (q_bit.size() != 0) tmo();
        bus_idle <= 1'b1;
        tx_active <= 1'b0;
    endtask

    // ********
    // Drivers and monitor
    // ********
    // New transmit bit after each request; note it once the edge has passed
    always @(posedge ref_clk) begin
        if (tx_bit_req === 1'b1) begin
            nb = 1'($urandom);
            tx_bit <= nb;
            @(negedge ref_clk);
            q_tx.push_back(nb);
        end
    end
    // Outputs sampled before this edge's updates land, so no race
    always @(posedge ref_clk) begin
        cyc++;
        if (rst === 1'b0) begin
            if (rd_pend) cmp_data(rd_data, q_rd.pop_front());
            else if (rd_data !== 8'h00) cmp_data(rd_data, 8'h00);
            if (tx_bit_req === 1'b1) begin
                if (q_per.size() != 0) cmp_time(cyc - t_req, q_per.pop_front());
                if (q_tx.size() != 0) cmp_bit(can_tx, q_tx.pop_front());
                t_req = cyc;
            end
            if (sample_strobe === 1'b1) begin
                if (q_smp.size() != 0) cmp_time(cyc - t_req, q_smp.pop_front());
                t_smp = cyc;
            end
            if (rx_bit_valid === 1'b1) begin
                if (q_val.size() != 0) cmp_time(cyc - t_smp, q_val.pop_front());
                if (q_bit.size() != 0 && !(hunt && rx_bit === 1'b1)) begin
                    hunt = 1'b0;
                    cmp_bit(rx_bit, q_bit.pop_front());
                end
            end
        end
        rd_pend = (rd_stb === 1'b1);
    end

    initial begin
        int k;
        void'($urandom(9408));
        ref_clk = 1'b0;
        rst = 1'b1;
        {wr_stb, rd_stb, tx_active, start, rd_pend, hunt} = '0;
        {tx_bit, bus_idle} = 2'b11;
        addr = 4'h0;
        wr_data = 8'h00;
        frame = '1;
        nbits = 7'h01;
        bit_clks = 8'h0A;
        {compares, miscompares, cyc, t_req, t_smp} = '0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(cbt_pkg::OFS_STATUS, 8'h14); // Reset state: can_tx 1, rx_bit 1, sync segment
        rd(cbt_pkg::OFS_PRESCALE, cbt_pkg::RST_PRESCALE);
        rd(cbt_pkg::OFS_SEGMENT, cbt_pkg::RST_SEGMENT);
        rd(cbt_pkg::OFS_PHASE2, cbt_pkg::RST_PHASE2);
        idle();
        timing(8'h00, 8'h00, 8'h00);
        timing(8'h00, 8'hBF, 8'h07);
        timing(8'h00, 8'h3F, 8'h00);
        timing(8'h01, 8'h80, 8'h00);
        for (k = 0; k < 4; k++) begin
            timing({2'($urandom), 4'h0, 2'($urandom)}, 8'($urandom), {5'h00, 3'($urandom)});
        end
        timing(8'hC3, 8'h91, 8'h02);
        send(8'h47, 1'b0);
        timing(8'hC3, 8'hD1, 8'h02);
        send(8'h49, 1'b1);
        stop_test();
    end
endmodule
